/* design/core_memory_pattern_tester.sv */
// local maintenance pattern generator, checker, continue and clear logic of a core memory module
`include "core_memory_pattern_tester_defs.svh"

module core_memory_pattern_tester #(
   parameter int ADDR_WIDTH = 12,
   parameter int BIT_COUNT = 6
) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst_n,
   // avalon-mm slave
   input wire logic [7:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   // core stack side
   input wire logic [BIT_COUNT-1:0] stack_read_data,
   input wire logic parity_error,
   output logic [BIT_COUNT-1:0] expected_bit_driver,
   output logic [BIT_COUNT-1:0] info_register,
   output logic [ADDR_WIDTH-1:0] addr_register,
   output logic write_cycle_ff,
   output logic worst_case_ff,
   output logic error_ff,
   output logic [1:0] pulse_counter,
   output logic continue_level,
   output logic single_cycle_level
);

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   function automatic logic [31:0] merge_lanes(input logic [31:0] old, input logic [31:0] wdata,
                                               input logic [3:0] be);
      logic [31:0] res;
      res = old;
      for (int i = 0; i < 4; i++)
      begin
         if (be[i])
         begin
            res[i*8 +: 8] = wdata[i*8 +: 8];
         end
      end
      return res;
   endfunction

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   core_memory_pattern_tester_pkg::panel_type panel;
   core_memory_pattern_tester_pkg::state_type state;
   logic [BIT_COUNT-1:0] bit_complement_level;
   logic bus_ack;
   logic bus_take;
   logic wr_panel;
   logic wr_bit_comp;
   logic wr_start;
   logic wr_info;
   logic wr_addr;
   logic start_pulse;
   logic [31:0] merged;
   logic [31:0] next_readdata;

   logic auto_pattern_level;
   logic manual_pattern_level;
   logic checkerboard_level;
   logic word_true_level;
   logic complement_mode_level;
   logic normal_mode_level;
   logic manual_switch_out;
   logic addr_bit_two;
   logic addr_bit_eight;
   logic pattern_stage_one;
   logic pattern_stage_two;
   logic pattern_stage_three;
   logic pattern_stage_four;
   logic check_enable_driver;
   logic [BIT_COUNT-1:0] bit_mismatch_switch;
   logic all_addr_ones_gate;
   logic stop_on_error_level;
   logic stop_final_addr_level;
   logic error_halt;
   logic final_halt;
   logic counter_zero_or_three;
   logic end_of_cycle;
   logic advance;
   logic clear_info;
   logic set_error;
   logic [2:0] cycle_number;

   // ----------------------------------------------------------------
   // avalon slave: one wait state on every access
   // ----------------------------------------------------------------
   assign bus_take = (avs_read | avs_write) & ~bus_ack;
   assign avs_waitrequest = (avs_read | avs_write) & ~bus_ack;
   assign merged = merge_lanes(32'h0000_0000, avs_writedata, avs_byteenable);
   assign wr_panel = bus_take & avs_write & (avs_address == `CMPT_OFS_PANEL);
   assign wr_bit_comp = bus_take & avs_write & (avs_address == `CMPT_OFS_BIT_COMP);
   assign wr_start = bus_take & avs_write & (avs_address == `CMPT_OFS_START);
   assign wr_info = bus_take & avs_write & (avs_address == `CMPT_OFS_INFO);
   assign wr_addr = bus_take & avs_write & (avs_address == `CMPT_OFS_ADDR);
   assign start_pulse = wr_start & merged[`CMPT_START_BIT];

   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         bus_ack <= 1'b0;
      end
      else
      begin
         bus_ack <= bus_take;
      end
   end

   always_comb
   begin
      next_readdata = 32'h0000_0000;
      case (avs_address)
         `CMPT_OFS_PANEL: next_readdata[`CMPT_PANEL_WIDTH-1:0] = panel;
         `CMPT_OFS_BIT_COMP: next_readdata[BIT_COUNT-1:0] = bit_complement_level;
         `CMPT_OFS_STATUS: next_readdata[12:0] = {cycle_number, pulse_counter, state == core_memory_pattern_tester_pkg::run,
                                                  single_cycle_level, continue_level, write_cycle_ff,
                                                  worst_case_ff, error_ff, 2'h0};
         `CMPT_OFS_INFO: next_readdata[BIT_COUNT-1:0] = info_register;
         `CMPT_OFS_ADDR: next_readdata[ADDR_WIDTH-1:0] = addr_register;
         default: next_readdata = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         avs_readdata <= 32'h0000_0000;
      end
      else if (bus_take & avs_read)
      begin
         avs_readdata <= next_readdata;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         panel <= `CMPT_PANEL_RESET;
         bit_complement_level <= '0;
      end
      else
      begin
         if (wr_panel)
         begin
            panel <= merged[`CMPT_PANEL_WIDTH-1:0];
         end
         if (wr_bit_comp)
         begin
            bit_complement_level <= merged[BIT_COUNT-1:0];
         end
      end
   end

   // ----------------------------------------------------------------
   // pattern generation
   // ----------------------------------------------------------------
   assign checkerboard_level = panel.checkerboard;
   assign auto_pattern_level = ~panel.checkerboard & panel.auto_select;
   assign manual_pattern_level = ~panel.checkerboard & ~panel.auto_select;
   assign manual_switch_out = manual_pattern_level;
   assign word_true_level = panel.word_true;
   assign complement_mode_level = panel.complement_mode;
   assign normal_mode_level = ~panel.complement_mode;
   assign addr_bit_two = addr_register[`CMPT_ADDR_LOW_BIT];
   assign addr_bit_eight = addr_register[`CMPT_ADDR_HIGH_BIT];

   // in checkerboard, stage one is true when the address bits agree and the word is true
   assign pattern_stage_one = checkerboard_level ? ~(addr_bit_two ^ addr_bit_eight) ^ ~word_true_level
                                                 : ~word_true_level;
   assign pattern_stage_two = ~pattern_stage_one;
   assign pattern_stage_three = (worst_case_ff & complement_mode_level) ? pattern_stage_two
                                                                         : pattern_stage_one;
   assign pattern_stage_four = ~pattern_stage_three & ~manual_switch_out;

   // each driver follows the pattern, inverted where its bit selector is set
   assign expected_bit_driver = {BIT_COUNT{pattern_stage_four}} ^ bit_complement_level;

   // ----------------------------------------------------------------
   // checking
   // ----------------------------------------------------------------
   assign check_enable_driver = (state == core_memory_pattern_tester_pkg::run) & ~manual_switch_out
                                & (pulse_counter == `CMPT_PC_CHECK);
   // read cycles hold stack data, write cycles the loaded pattern
   assign bit_mismatch_switch = expected_bit_driver ^ info_register;
   assign set_error = (check_enable_driver & (|bit_mismatch_switch)) | parity_error;

   // cycle of a worst case word, 1..4, from the write and worst case flags
   assign cycle_number = {1'b0, write_cycle_ff ^ worst_case_ff, write_cycle_ff}
                         + 3'h1;

   // ----------------------------------------------------------------
   // continue logic
   // ----------------------------------------------------------------
   assign single_cycle_level = ~panel.continuous;
   assign stop_on_error_level = panel.stop_on_error;
   assign stop_final_addr_level = panel.stop_final;
   assign all_addr_ones_gate = &addr_register;
   assign error_halt = stop_on_error_level & error_ff;
   assign final_halt = stop_final_addr_level & all_addr_ones_gate
                       & (manual_pattern_level
                          | (write_cycle_ff & ~worst_case_ff));
   assign continue_level = panel.local_mode & panel.continuous & ~error_halt & ~final_halt;

   assign end_of_cycle = (state == core_memory_pattern_tester_pkg::run) & (pulse_counter == `CMPT_PC_END);
   // a halted cycle leaves the word sequence where it stopped
   assign advance = end_of_cycle & ~error_halt & ~final_halt;
   assign counter_zero_or_three = (pulse_counter == `CMPT_PC_ZERO) | (pulse_counter == `CMPT_PC_END);

   // ----------------------------------------------------------------
   // cycle sequencing
   // ----------------------------------------------------------------
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state <= core_memory_pattern_tester_pkg::idle;
         pulse_counter <= `CMPT_PC_ZERO;
      end
      else
      begin
         case (state)
            core_memory_pattern_tester_pkg::idle:
            begin
               if (start_pulse & panel.local_mode)
               begin
                  state <= core_memory_pattern_tester_pkg::run;
                  pulse_counter <= `CMPT_PC_ZERO;
               end
            end
            core_memory_pattern_tester_pkg::run:
            begin
               if (pulse_counter != `CMPT_PC_END)
               begin
                  pulse_counter <= pulse_counter + 2'h1;
               end
               else if (continue_level)
               begin
                  pulse_counter <= `CMPT_PC_ZERO;
               end
               else
               begin
                  state <= core_memory_pattern_tester_pkg::idle;
               end
            end
            default: state <= core_memory_pattern_tester_pkg::idle;
         endcase
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         write_cycle_ff <= 1'b0;
         worst_case_ff <= 1'b0;
      end
      else if (manual_pattern_level)
      begin
         write_cycle_ff <= panel.manual_write;
         worst_case_ff <= 1'b0;
      end
      else if (advance)
      begin
         write_cycle_ff <= ~write_cycle_ff;
         if (!write_cycle_ff)
         begin
            // set entering cycle two, cleared entering cycle four
            worst_case_ff <= complement_mode_level & ~worst_case_ff;
         end
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         addr_register <= '0;
      end
      else if (advance & (manual_pattern_level | (write_cycle_ff & ~worst_case_ff)))
      begin
         addr_register <= addr_register + 1'b1;
      end
      else if (wr_addr)
      begin
         addr_register <= merged[ADDR_WIDTH-1:0];
      end
   end

   // ----------------------------------------------------------------
   // information register and error flag clearing
   // ----------------------------------------------------------------
   always_comb
   begin
      clear_info = 1'b0;
      if (end_of_cycle & continue_level)
      begin
         if (!write_cycle_ff)
         begin
            clear_info = 1'b1;
         end
         else if (!manual_pattern_level)
         begin
            clear_info = 1'b1;
         end
      end
      // an error halt keeps its evidence until software clears stop on error
      else if ((state == core_memory_pattern_tester_pkg::idle) & counter_zero_or_three & ~error_halt
               & ~(manual_pattern_level & write_cycle_ff))
      begin
         clear_info = 1'b1;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         info_register <= '0;
      end
      else if ((state == core_memory_pattern_tester_pkg::run) & (pulse_counter == `CMPT_PC_LOAD)
               & ~(manual_pattern_level & write_cycle_ff))
      begin
         info_register <= write_cycle_ff ? expected_bit_driver : stack_read_data;
      end
      else if (clear_info)
      begin
         info_register <= '0;
      end
      else if (wr_info)
      begin
         info_register <= merged[BIT_COUNT-1:0];
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         error_ff <= 1'b0;
      end
      else if (set_error)
      begin
         error_ff <= 1'b1;
      end
      else if (clear_info)
      begin
         error_ff <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   a_normal_no_worst: assert property (@(posedge ref_clk) disable iff (!rst_n)
      $rose(worst_case_ff) |-> $past(complement_mode_level))
      else $error("worst case flag set in normal mode");

   a_worst_set_second: assert property (@(posedge ref_clk) disable iff (!rst_n)
      $rose(worst_case_ff) |-> write_cycle_ff && $past(end_of_cycle) && !$past(write_cycle_ff))
      else $error("worst case flag set outside start of cycle two");

   a_worst_clear_fourth: assert property (@(posedge ref_clk) disable iff (!rst_n)
      $fell(worst_case_ff) && !manual_pattern_level |-> write_cycle_ff && !$past(write_cycle_ff))
      else $error("worst case flag cleared outside start of cycle four");

   a_checker_true: assert property (@(posedge ref_clk) disable iff (!rst_n)
      checkerboard_level && word_true_level && !worst_case_ff && bit_complement_level == '0
      |-> expected_bit_driver == {BIT_COUNT{addr_bit_two ^ addr_bit_eight}})
      else $error("checkerboard pattern wrong");

   a_word_complement: assert property (@(posedge ref_clk) disable iff (!rst_n)
      checkerboard_level && !word_true_level && !worst_case_ff && bit_complement_level == '0
      |-> expected_bit_driver == {BIT_COUNT{addr_bit_two == addr_bit_eight}})
      else $error("complemented checkerboard pattern wrong");

   a_check_sets_error: assert property (@(posedge ref_clk) disable iff (!rst_n)
      check_enable_driver && (expected_bit_driver != info_register) |=> error_ff [*1] ##1 1'b1)
      else $error("mismatch at pulse two did not set error");

   a_manual_no_compare: assert property (@(posedge ref_clk) disable iff (!rst_n)
      $rose(error_ff) && $past(manual_pattern_level) |-> $past(parity_error))
      else $error("compare set error in manual mode");

   a_single_no_continue: assert property (@(posedge ref_clk) disable iff (!rst_n)
      !panel.continuous |-> !continue_level && single_cycle_level)
      else $error("continue true in single cycle mode");

   a_error_stops: assert property (@(posedge ref_clk) disable iff (!rst_n)
      end_of_cycle && stop_on_error_level && error_ff
      |=> state == core_memory_pattern_tester_pkg::idle && error_ff)
      else $error("stop on error did not halt with error kept");

   a_addr_word_end: assert property (@(posedge ref_clk) disable iff (!rst_n)
      advance && !manual_pattern_level && !(write_cycle_ff && !worst_case_ff) && !wr_addr
      |=> addr_register == $past(addr_register))
      else $error("address counted before end of word");

   a_cycle_attrib: assert property (@(posedge ref_clk) disable iff (!rst_n)
      cycle_number == (worst_case_ff ? (write_cycle_ff ? 3'h2 : 3'h3) : (write_cycle_ff ? 3'h4 : 3'h1)))
      else $error("cycle number does not match write and worst case flags");

endmodule

/* pkg/core_memory_pattern_tester_defs.svh */
// register offsets, field positions, reset values and pulse counter figures of the pattern tester
`ifndef CORE_MEMORY_PATTERN_TESTER_DEFS_SVH
`define CORE_MEMORY_PATTERN_TESTER_DEFS_SVH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define CMPT_OFS_PANEL 8'h00
`define CMPT_OFS_BIT_COMP 8'h04
`define CMPT_OFS_START 8'h08
`define CMPT_OFS_STATUS 8'h0C
`define CMPT_OFS_INFO 8'h10
`define CMPT_OFS_ADDR 8'h14

// ----------------------------------------------------------------
// panel register width and reset value, start register field position
// ----------------------------------------------------------------
`define CMPT_PANEL_WIDTH 9
`define CMPT_PANEL_RESET 9'h000
`define CMPT_START_BIT 0

// ----------------------------------------------------------------
// pulse counter values
// ----------------------------------------------------------------
`define CMPT_PC_ZERO 2'h0
`define CMPT_PC_LOAD 2'h1
`define CMPT_PC_CHECK 2'h2
`define CMPT_PC_END 2'h3

// ----------------------------------------------------------------
// address bits that pick the checkerboard phase
// ----------------------------------------------------------------
`define CMPT_ADDR_LOW_BIT 2
`define CMPT_ADDR_HIGH_BIT 8

`endif

/* pkg/core_memory_pattern_tester_pkg.sv */
// types shared by the pattern tester
package core_memory_pattern_tester_pkg;

   // panel switch image, msb first as laid out in the panel register
   typedef struct packed {
      logic manual_write;
      logic word_true;
      logic complement_mode;
      logic auto_select;
      logic checkerboard;
      logic stop_final;
      logic stop_on_error;
      logic continuous;
      logic local_mode;
   } panel_type;

   typedef enum logic [1:0] {
      idle = 2'b01,
      run = 2'b10
   } state_type;

endpackage

/* test/core_stack_model.sv */
// core stack model answering the pattern tester
module core_stack_model #(
   parameter int ADDR_WIDTH = 12,
   parameter int BIT_COUNT = 6
) (
   // clock
   input wire logic ref_clk,
   // tester side
   input wire logic [ADDR_WIDTH-1:0] addr_register,
   input wire logic [BIT_COUNT-1:0] info_register,
   input wire logic write_cycle_ff,
   input wire logic [1:0] pulse_counter,
   output logic [BIT_COUNT-1:0] stack_read_data,
   // fault injection
   input wire logic [BIT_COUNT-1:0] corrupt_mask
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [BIT_COUNT-1:0] mem [2**ADDR_WIDTH];
   logic [BIT_COUNT-1:0] word;
   // ----------------------------------------------------------------
   // storage
   // ----------------------------------------------------------------
   initial
   begin
      foreach (mem[i])
      begin
         mem[i] = '0;
      end
   end
   // the information register loads at the end of pulse one, so pulse two is a safe store point
   always @(posedge ref_clk)
   begin
      if (write_cycle_ff && pulse_counter == 2'h2)
      begin
         mem[addr_register] <= info_register;
      end
   end
   // sense data settles only at pulse one of a read; elsewhere the lines show the inverse
   assign word = mem[addr_register] ^ corrupt_mask;
   assign stack_read_data = (!write_cycle_ff && pulse_counter == 2'h1) ? word : ~word;
endmodule

/* test/core_memory_pattern_tester_tb_top.sv */
// self-checking bench of the core memory pattern tester
`include "core_memory_pattern_tester_defs.svh"
module core_memory_pattern_tester_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   // ----------------------------------------------------------------
   // panel bits, offsets, signals
   // ----------------------------------------------------------------
   localparam logic [8:0] LOC = 9'h001, CNT = 9'h002, SOE = 9'h004, SFA = 9'h008, CHK = 9'h010;
   localparam logic [8:0] AUT = 9'h020, CMP = 9'h040, WTR = 9'h080, MWR = 9'h100;
   localparam logic [7:0] PNL = `CMPT_OFS_PANEL, BCP = `CMPT_OFS_BIT_COMP, STR = `CMPT_OFS_START;
   localparam logic [7:0] STA = `CMPT_OFS_STATUS, INF = `CMPT_OFS_INFO, ADR = `CMPT_OFS_ADDR;
   logic ref_clk, rst_n, avs_read, avs_write, avs_waitrequest, parity_error;
   logic [7:0] avs_address;
   logic [31:0] avs_writedata, avs_readdata;
   logic [3:0] avs_byteenable;
   logic [5:0] stack_read_data, expected_bit_driver, info_register, corrupt_mask;
   logic [11:0] addr_register;
   logic write_cycle_ff, worst_case_ff, error_ff, continue_level, single_cycle_level;
   logic [1:0] pulse_counter;
   int n_errors, checked;
   core_memory_pattern_tester #(.ADDR_WIDTH(12), .BIT_COUNT(6)) i_dut (
      .ref_clk, .rst_n, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable,
      .avs_readdata, .avs_waitrequest, .stack_read_data, .parity_error, .expected_bit_driver,
      .info_register, .addr_register, .write_cycle_ff, .worst_case_ff, .error_ff, .pulse_counter,
      .continue_level, .single_cycle_level);
   core_stack_model #(.ADDR_WIDTH(12), .BIT_COUNT(6)) i_stack (
      .ref_clk, .addr_register, .info_register, .write_cycle_ff, .pulse_counter,
      .stack_read_data, .corrupt_mask);
   // ----------------------------------------------------------------
   // shared tasks
   // ----------------------------------------------------------------
   task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] g);
      checked++;
      if (g !== e)
      begin
         n_errors++;
         $display("[FAIL] %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic cmpb(input string n, input logic e, input logic g);
      cmp(n, 32'(e), 32'(g));
   endtask
   // one idle edge before each request keeps release and next request apart
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
      @(posedge ref_clk);
      avs_address <= a;
      avs_writedata <= wd;
      avs_write <= w;
      avs_read <= !w;
      do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
      rd = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] x;
      bus(1'b1, a, d, x);
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      bus(1'b0, a, 32'h0, d);
   endtask
   task automatic wait_pc(input logic [1:0] v);
      int i;
      i = 0;
      do
      begin
         @(negedge ref_clk);
         i++;
      end
      while (pulse_counter !== v && i < 100);
      cmpb("counter reached", 1'b1, i < 100);
   endtask
   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   task automatic t_reset();
      logic [31:0] d;
      rd(STA, d);
      cmp("status reset", 32'h40, d & 32'h3FF);
      rd(PNL, d);
      cmp("panel reset", 32'h0, d);
      wr(8'h20, 32'hFFFFFFFF);
      rd(8'h20, d);
      cmp("unmapped", 32'h0, d);
   endtask
   task automatic t_patterns();
      logic [5:0] e;
      wr(BCP, 32'h25);
      // m: bit0 addr bit two, bit1 addr bit eight, bit2 word true, bit3 uniform auto
      for (int m = 0; m < 16; m++)
      begin
         wr(PNL, 32'(LOC | (m[3] ? AUT : CHK) | (m[2] ? WTR : 9'h000)));
         wr(ADR, {23'h0, m[1], 5'h0, m[0], 2'h0});
         e = {6{m[3] ? m[2] : (m[0] ^ m[1] ^ !m[2])}} ^ 6'h25;
         @(negedge ref_clk);
         cmp("pattern", 32'(e), 32'(expected_bit_driver));
      end
      wr(PNL, 32'(LOC));
      @(negedge ref_clk);
      cmp("manual pattern", 32'h25, 32'(expected_bit_driver));
      wr(BCP, 32'h0);
      wr(PNL, 32'(LOC | CHK));
      @(negedge ref_clk);
      cmp("complement pattern", 32'h3F, 32'(expected_bit_driver));
   endtask
   task automatic t_run(input logic worst, input logic [11:0] a0);
      logic [31:0] d;
      logic wc;
      // a halted run keeps its word sequence; manual read puts it back at cycle one
      wr(PNL, 32'(LOC));
      wr(BCP, 32'h0);
      wr(ADR, 32'(a0));
      wr(PNL, 32'(LOC | CNT | SFA | CHK | WTR | (worst ? CMP : 9'h000)));
      wr(STR, 32'h1);
      for (int i = 0; i < 4; i++)
      begin
         wc = worst & (i[1] ^ i[0]);
         // the start write returns with the first cycle already past pulse zero
         if (i == 0)
         begin
            @(negedge ref_clk);
         end
         else
         begin
            wait_pc(2'h0);
         end
         cmp("info cleared", 32'h0, 32'(info_register));
         wait_pc(2'h2);
         cmpb("write flag", i[0], write_cycle_ff);
         cmpb("worst flag", wc, worst_case_ff);
         cmp("driver", 32'({6{wc}}), 32'(expected_bit_driver));
         cmp("address", 32'(worst ? a0 : a0 + 12'(i / 2)), 32'(addr_register));
         cmpb("continue", i != 3, continue_level);
         wait_pc(2'h3);
         cmpb("error", 1'b0, error_ff);
      end
      repeat (3) @(negedge ref_clk);
      cmp("counter stop", 32'h3, 32'(pulse_counter));
      cmp("address stop", 32'(a0 + 12'(!worst)), 32'(addr_register));
      rd(STA, d);
      cmpb("running", 1'b0, d[7]);
      cmp("cycle number", 32'h4, 32'(d[12:10]));
   endtask
   task automatic t_error();
      @(posedge ref_clk);
      corrupt_mask <= 6'h04;
      wr(PNL, 32'(LOC));
      wr(ADR, 32'h0);
      wr(PNL, 32'(LOC | CNT | SOE | CHK | WTR));
      wr(STR, 32'h1);
      wait_pc(2'h2);
      wait_pc(2'h3);
      cmpb("error set", 1'b1, error_ff);
      cmpb("continue err", 1'b0, continue_level);
      repeat (6) @(negedge ref_clk);
      cmp("info held", 32'h04, 32'(info_register));
      cmpb("error held", 1'b1, error_ff);
      @(posedge ref_clk);
      corrupt_mask <= 6'h00;
      wr(PNL, 32'(LOC | CHK | WTR));
      repeat (3) @(negedge ref_clk);
      cmp("idle clear", 32'h0, {25'h0, error_ff, info_register});
      wr(PNL, 32'(LOC | CNT | SOE | CHK | WTR));
      @(posedge ref_clk);
      parity_error <= 1'b1;
      @(posedge ref_clk);
      parity_error <= 1'b0;
      @(negedge ref_clk);
      cmpb("parity error", 1'b1, error_ff);
      cmpb("continue parity", 1'b0, continue_level);
      wr(PNL, 32'(LOC | CHK | WTR));
   endtask
   task automatic t_manual();
      wr(BCP, 32'h0);
      wr(ADR, 32'h010);
      // manual write must stand first, or the idle clear wipes the loaded word
      wr(PNL, 32'(LOC | MWR));
      wr(INF, 32'h2A);
      @(negedge ref_clk);
      cmpb("single", 1'b1, single_cycle_level);
      cmpb("continue single", 1'b0, continue_level);
      wr(STR, 32'h1);
      wait_pc(2'h2);
      wait_pc(2'h3);
      repeat (3) @(negedge ref_clk);
      cmp("manual info", 32'h2A, 32'(info_register));
      cmp("manual address", 32'h011, 32'(addr_register));
      wr(ADR, 32'h010);
      wr(PNL, 32'(LOC));
      wr(STR, 32'h1);
      wait_pc(2'h2);
      cmp("manual read", 32'h2A, 32'(info_register));
      wait_pc(2'h3);
      cmpb("manual error", 1'b0, error_ff);
      repeat (3) @(negedge ref_clk);
      cmp("read cleared", 32'h0, 32'(info_register));
      wr(ADR, 32'hFFF);
      wr(PNL, 32'(LOC | CNT | SFA));
      @(negedge ref_clk);
      cmpb("manual final", 1'b0, continue_level);
      wr(ADR, 32'hFFE);
      @(negedge ref_clk);
      cmpb("continuous", 1'b1, continue_level);
   endtask
   task automatic conclude();
      $display("checks %0d mismatches %0d", checked, n_errors);
      if (n_errors == 0 && checked > 0)
      begin
         $display("Run complete: PASS");
      end
      else
      begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   // ----------------------------------------------------------------
   // clock, watchdog, main sequence
   // ----------------------------------------------------------------
   initial
   begin
      ref_clk = 1'b0;
      forever #2.5 ref_clk = ~ref_clk;
   end
   initial
   begin
      #40000;
      n_errors++;
      $display("[FAIL] watchdog expected end seen timeout");
      conclude();
   end
   initial
   begin
      {rst_n, avs_read, avs_write, parity_error} = 4'h0;
      avs_address = 8'h00;
      avs_writedata = 32'h0;
      avs_byteenable = 4'hF;
      corrupt_mask = 6'h00;
      n_errors = 0;
      checked = 0;
      repeat (6) @(posedge ref_clk);
      rst_n <= 1'b1;
      t_reset();
      t_patterns();
      t_run(1'b0, 12'hFFE);
      t_run(1'b1, 12'hFFF);
      t_error();
      t_manual();
      conclude();
   end
endmodule
